// ===== core/tacr_regs.sv
// Thermal alarm configuration registers and switching output control
module tacr_regs (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Decoded register access from the serial framer
	input tacr_pkg::tacr_req_t REQ,
	output tacr_pkg::tacr_rsp_t RSP,
	// Non-volatile store image
	input wire logic NV_VALID,
	input wire logic [16*tacr_pkg::HOLD_NUM-1:0] NV_HOLD,
	input wire logic [3:0] NV_COILS,
	output logic NV_SAVE,
	// Analysis results, compared against thresholds
	input wire logic [15:0] FUNC1_MIN,
	input wire logic [15:0] FUNC1_MAX,
	input wire logic [15:0] FUNC2_TEMP,
	input wire logic [15:0] FUNC3_TEMP,
	input wire logic [7:0] FUNC_EN,
	// Configuration outputs
	output logic [16*tacr_pkg::HOLD_NUM-1:0] HOLD_OUT,
	output logic [3:0] COIL_OUT,
	output logic FRAME_FREEZE,
	output logic COUNTER_RESET,
	output tacr_pkg::tacr_alarm_t ALARM,
	output logic SOFT_ALARM,
	output logic OUTPUT_CLEAR,
	output logic SWITCH_OUT,
	output logic SWITCH_DRIVE_SINK
);
	import tacr_pkg::*;

	logic [15:0] hold_q [HOLD_NUM];
	logic [3:0] coil_q;
	logic drive_latched_q;
	logic freeze_q;
	logic clear_q;
	logic cnt_rst_q;
	logic load_q;
	logic [15:0] lo_limit [HOLD_NUM];
	logic [15:0] hi_limit [HOLD_NUM];
	logic [15:0] rst_val [HOLD_NUM];
	logic [3:0] hidx;
	logic hold_hit;
	logic value_ok;
	logic wr_hold;
	logic wr_coil;
	logic coil_val;
	tacr_alarm_t alarm;
	logic any_alarm;
	tacr_out_state_t state_q;
	logic [31:0] tmr_q;
	logic [31:0] on_cycles;
	logic out_active;

	always_comb begin
		for (int i = 0; i < HOLD_NUM; i++) begin
			lo_limit[i] = THR_MIN;
			hi_limit[i] = THR_MAX;
			rst_val[i] = (i % 2 == 0) ? HOT_RST : COLD_RST;
		end
		lo_limit[6] = ON_MIN; hi_limit[6] = ON_MAX; rst_val[6] = ON_RST;
		lo_limit[7] = EMISS_MIN; hi_limit[7] = EMISS_MAX;
		rst_val[7] = EMISS_RST;
		lo_limit[8] = AREA_MIN; hi_limit[8] = AREA_MAX;
		rst_val[8] = AREA_RST;
		lo_limit[9] = AVG_MIN; hi_limit[9] = AVG_MAX; rst_val[9] = AVG_RST;
		lo_limit[10] = REGION_MIN; hi_limit[10] = REGION_MAX;
		rst_val[10] = REGION_RST;
		lo_limit[11] = MODE_MIN; hi_limit[11] = MODE_MAX;
		rst_val[11] = MODE_RST;
	end

	// Address decode and range check
	assign hidx = 4'(REQ.addr - HR_F1_HOT);
	assign hold_hit = REQ.addr >= HR_F1_HOT && REQ.addr <= HR_MODE;
	always_comb begin
		value_ok = hold_hit && REQ.data >= lo_limit[hidx]
			&& REQ.data <= hi_limit[hidx];
		if (REQ.addr == HR_AREA && REQ.data[0]) begin
			value_ok = 1'b0;
		end
	end
	assign wr_hold = REQ.valid && REQ.write && !REQ.is_coil && value_ok;
	assign wr_coil = REQ.valid && REQ.write && REQ.is_coil;
	assign coil_val = REQ.data != 16'h0000;

	// Holding registers: stored copy or defaults at reset
	generate
		for (genvar g = 0; g < HOLD_NUM; g++) begin : g_hold
			always_ff @(posedge CLK) begin
				if (SYS_RST) begin
					hold_q[g] <= rst_val[g];
				end else if (load_q && NV_VALID) begin
					hold_q[g] <= NV_HOLD[16*g +: 16];
				end else if (wr_hold && hidx == 4'(g)) begin
					hold_q[g] <= REQ.data;
				end
			end
			assign HOLD_OUT[16*g +: 16] = hold_q[g];
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			load_q <= 1'b1;
		end else begin
			load_q <= 1'b0;
		end
	end

	// Persistent coils
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			coil_q <= COIL_RST;
		end else if (load_q && NV_VALID) begin
			coil_q <= NV_COILS;
		end else if (wr_coil && REQ.addr < 16'h0004) begin
			coil_q[REQ.addr[1:0]] <= coil_val;
		end
	end

	// Drive type only follows the coil after a restart
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			drive_latched_q <= COIL_RST[3];
		end else if (load_q) begin
			drive_latched_q <= NV_VALID ? NV_COILS[3] : coil_q[3];
		end
	end

	// Runtime-only flags, never saved
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			freeze_q <= 1'b0;
			cnt_rst_q <= 1'b0;
		end else begin
			if (wr_coil && REQ.addr == COIL_FREEZE) begin
				freeze_q <= coil_val;
			end
			if (wr_coil && REQ.addr == COIL_CNT_RST) begin
				cnt_rst_q <= coil_val;
			end
		end
	end

	// Threshold comparisons gated by mode
	always_comb begin
		alarm.hot1 = hold_q[11][0] && FUNC1_MAX > hold_q[0];
		alarm.cold1 = hold_q[11][1] && FUNC1_MIN < hold_q[1];
		alarm.hot2 = hold_q[11][0] && FUNC2_TEMP > hold_q[2];
		alarm.cold2 = hold_q[11][1] && FUNC2_TEMP < hold_q[3];
		alarm.hot3 = hold_q[11][0] && FUNC3_TEMP > hold_q[4];
		alarm.cold3 = hold_q[11][1] && FUNC3_TEMP < hold_q[5];
		alarm.hot1 = alarm.hot1 && FUNC_EN[0];
		alarm.cold1 = alarm.cold1 && FUNC_EN[0];
		alarm.hot2 = alarm.hot2 && FUNC_EN[1];
		alarm.cold2 = alarm.cold2 && FUNC_EN[1];
		alarm.hot3 = alarm.hot3 && FUNC_EN[2];
		alarm.cold3 = alarm.cold3 && FUNC_EN[2];
	end
	assign any_alarm = |alarm;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ALARM <= '0;
			SOFT_ALARM <= 1'b0;
		end else begin
			ALARM <= alarm;
			SOFT_ALARM <= any_alarm;
		end
	end

	// Switching output sequencer
	assign on_cycles = 32'(hold_q[6]) * 32'(MS_CYCLES);
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_q <= TA_IDLE;
			tmr_q <= '0;
		end else begin
			case (state_q)
				TA_IDLE: begin
					if (any_alarm && coil_q[0]) begin
						state_q <= TA_ON;
						tmr_q <= '0;
					end
				end
				TA_ON: begin
					if (!coil_q[1]) begin
						if (!clear_q) begin
							state_q <= TA_IDLE;
						end
					end else if (tmr_q + 32'd1 >= on_cycles) begin
						state_q <= TA_GAP;
						tmr_q <= '0;
					end else begin
						tmr_q <= tmr_q + 32'd1;
					end
				end
				TA_GAP: begin
					if (tmr_q + 32'd1 >= 32'(GAP_CYCLES)) begin
						state_q <= TA_IDLE;
						tmr_q <= '0;
					end else begin
						tmr_q <= tmr_q + 32'd1;
					end
				end
				default: state_q <= TA_IDLE;
			endcase
		end
	end
	// Disabling the output gates a pulse already under way
	assign out_active = state_q == TA_ON && coil_q[0];

	// Output-clear flag: set wins over the master clear
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			clear_q <= 1'b0;
		end else if (state_q == TA_IDLE && any_alarm && coil_q[0]) begin
			clear_q <= 1'b1;
		end else if (wr_coil && REQ.addr == COIL_CLEAR) begin
			clear_q <= coil_val;
		end else if (state_q == TA_ON && coil_q[1]
			&& tmr_q + 32'd1 >= on_cycles) begin
			clear_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SWITCH_OUT <= COIL_RST[2];
		end else begin
			SWITCH_OUT <= out_active ^ coil_q[2];
		end
	end
	assign SWITCH_DRIVE_SINK = drive_latched_q;
	assign COIL_OUT = coil_q;
	assign FRAME_FREEZE = freeze_q;
	assign COUNTER_RESET = cnt_rst_q;
	assign OUTPUT_CLEAR = clear_q;

	// Answers; broadcasts stay silent
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			RSP <= '0;
			NV_SAVE <= 1'b0;
		end else begin
			RSP.valid <= REQ.valid && REQ.slave != BCAST_ADDR;
			RSP.error <= REQ.valid && REQ.write && !REQ.is_coil && !value_ok;
			RSP.exc_code <= (REQ.write && !REQ.is_coil && !value_ok)
				? EXC_ILLEGAL_VALUE : 8'h00;
			NV_SAVE <= wr_hold || (wr_coil && REQ.addr < 16'h0004);
			if (REQ.is_coil) begin
				case (REQ.addr)
					COIL_OUT_EN: RSP.data <= {15'h0000, coil_q[0]};
					COIL_TIMER: RSP.data <= {15'h0000, coil_q[1]};
					COIL_SENSE: RSP.data <= {15'h0000, coil_q[2]};
					COIL_DRIVE: RSP.data <= {15'h0000, coil_q[3]};
					COIL_FREEZE: RSP.data <= {15'h0000, freeze_q};
					COIL_CLEAR: RSP.data <= {15'h0000, clear_q};
					COIL_CNT_RST: RSP.data <= {15'h0000, cnt_rst_q};
					default: RSP.data <= 16'h0000;
				endcase
			end else begin
				RSP.data <= hold_hit ? hold_q[hidx] : 16'h0000;
			end
		end
	end
endmodule

// ===== core/tacr_pkg.sv
// Package for the thermal alarm configuration register bank
package tacr_pkg;
	localparam int HOLD_NUM = 12;
	localparam logic [15:0] HR_F1_HOT = 16'h0002;
	localparam logic [15:0] HR_F1_COLD = 16'h0003;
	localparam logic [15:0] HR_F2_HOT = 16'h0004;
	localparam logic [15:0] HR_F2_COLD = 16'h0005;
	localparam logic [15:0] HR_F3_HOT = 16'h0006;
	localparam logic [15:0] HR_F3_COLD = 16'h0007;
	localparam logic [15:0] HR_ON_TIME = 16'h0008;
	localparam logic [15:0] HR_EMISS = 16'h0009;
	localparam logic [15:0] HR_AREA = 16'h000a;
	localparam logic [15:0] HR_AVG = 16'h000b;
	localparam logic [15:0] HR_REGION = 16'h000c;
	localparam logic [15:0] HR_MODE = 16'h000d;
	localparam logic [15:0] COIL_OUT_EN = 16'h0000;
	localparam logic [15:0] COIL_TIMER = 16'h0001;
	localparam logic [15:0] COIL_SENSE = 16'h0002;
	localparam logic [15:0] COIL_DRIVE = 16'h0003;
	localparam logic [15:0] COIL_FREEZE = 16'h0008;
	localparam logic [15:0] COIL_CLEAR = 16'h000b;
	localparam logic [15:0] COIL_CNT_RST = 16'h000c;
	localparam logic [15:0] THR_MIN = 16'h09e3;
	localparam logic [15:0] THR_MAX = 16'h24d7;
	localparam logic [15:0] HOT_RST = 16'h0e93;
	localparam logic [15:0] COLD_RST = 16'h0aab;
	localparam logic [15:0] ON_MIN = 16'h0032;
	localparam logic [15:0] ON_MAX = 16'h07d0;
	localparam logic [15:0] ON_RST = 16'h00fa;
	localparam logic [15:0] EMISS_MIN = 16'h0001;
	localparam logic [15:0] EMISS_MAX = 16'h0064;
	localparam logic [15:0] EMISS_RST = 16'h005f;
	localparam logic [15:0] AREA_MIN = 16'h0002;
	localparam logic [15:0] AREA_MAX = 16'h0020;
	localparam logic [15:0] AREA_RST = 16'h0004;
	localparam logic [15:0] AVG_MIN = 16'h0001;
	localparam logic [15:0] AVG_MAX = 16'h0010;
	localparam logic [15:0] AVG_RST = 16'h000a;
	localparam logic [15:0] REGION_MIN = 16'h0001;
	localparam logic [15:0] REGION_MAX = 16'h0004;
	localparam logic [15:0] REGION_RST = 16'h0003;
	localparam logic [15:0] MODE_MIN = 16'h0001;
	localparam logic [15:0] MODE_MAX = 16'h0003;
	localparam logic [15:0] MODE_RST = 16'h0001;
	localparam logic [3:0] COIL_RST = 4'ha;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam int CLK_MHZ = 100;
	localparam int MS_CYCLES = 1000 * CLK_MHZ;
	localparam int GAP_MS = 75;
	localparam int GAP_CYCLES = GAP_MS * MS_CYCLES;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

	typedef enum {TA_IDLE, TA_ON, TA_GAP} tacr_out_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic is_coil;
		logic [7:0] slave;
		logic [15:0] addr;
		logic [15:0] data;
	} tacr_req_t;

	typedef struct packed {
		logic valid;
		logic error;
		logic [7:0] exc_code;
		logic [15:0] data;
	} tacr_rsp_t;

	typedef struct packed {
		logic hot1;
		logic cold1;
		logic hot2;
		logic cold2;
		logic hot3;
		logic cold3;
	} tacr_alarm_t;
endpackage

// ===== verification/tacr_regs_asserts.sv
// Port checker for the register bank
module tacr_regs_asserts (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Access and answer
	input tacr_pkg::tacr_req_t REQ,
	input tacr_pkg::tacr_rsp_t RSP,
	input wire logic NV_SAVE,
	// Configuration image
	input wire logic [16*tacr_pkg::HOLD_NUM-1:0] HOLD_OUT,
	input wire logic [3:0] COIL_OUT,
	input wire logic SWITCH_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	import tacr_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_hwr(a);
		REQ.valid && REQ.write && !REQ.is_coil && REQ.addr == a;
	endsequence
	sequence s_refused;
		RSP.valid && RSP.error && RSP.exc_code == EXC_ILLEGAL_VALUE;
	endsequence
	property p_bcast_quiet;
		REQ.valid && REQ.slave == BCAST_ADDR |=> !RSP.valid;
	endproperty
	a_bcast_quiet: assert property (p_bcast_quiet)
		else $error("reply to a broadcast");
	property p_answer;
		REQ.valid && REQ.slave != BCAST_ADDR |=> RSP.valid;
	endproperty
	a_answer: assert property (p_answer)
		else $error("addressed request not answered");
	property p_mode_bad;
		s_hwr(HR_MODE) ##0 (REQ.slave != 0 && REQ.data > MODE_MAX)
			|=> s_refused ##0 $stable(HOLD_OUT[191:176]);
	endproperty
	a_mode_bad: assert property (p_mode_bad)
		else $error("bad mode value accepted");
	property p_area_odd;
		s_hwr(HR_AREA) ##0 (REQ.slave != 0 && REQ.data[0])
			|=> s_refused ##0 $stable(HOLD_OUT[143:128]);
	endproperty
	a_area_odd: assert property (p_area_odd)
		else $error("odd area size accepted");
	property p_thr_low;
		s_hwr(HR_F1_COLD) ##0 (REQ.slave != 0 && REQ.data < THR_MIN)
			|=> s_refused;
	endproperty
	a_thr_low: assert property (p_thr_low)
		else $error("low threshold accepted");
	property p_thr_ok;
		s_hwr(HR_F2_HOT) ##0 REQ.data inside {[THR_MIN:THR_MAX]}
			|=> HOLD_OUT[47:32] == $past(REQ.data) && NV_SAVE;
	endproperty
	a_thr_ok: assert property (p_thr_ok)
		else $error("valid threshold not stored");
	property p_coil_sense;
		REQ.valid && REQ.write && REQ.is_coil && REQ.addr == COIL_SENSE
			|=> COIL_OUT[2] == (|$past(REQ.data));
	endproperty
	a_coil_sense: assert property (p_coil_sense)
		else $error("sense coil not written");
	property p_gated;
		(!COIL_OUT[0] && $stable(COIL_OUT[2])) [*3]
			|-> SWITCH_OUT == COIL_OUT[2];
	endproperty
	a_gated: assert property (p_gated)
		else $error("output active while disabled");
endmodule

// ===== verification/tacr_master.sv
// Bus master model issuing decoded register requests
module tacr_master (
	// Clock
	input wire logic CLK,
	// Request to the bank
	output tacr_pkg::tacr_req_t REQ
);
	timeunit 1ns;
	timeprecision 1ps;
	import tacr_pkg::*;
	initial REQ = '0;
	// One-cycle request; released fields are scrambled
	task automatic xfer(input logic wr, co, input logic [7:0] sl,
		input logic [15:0] a, d);
		@(posedge CLK);
		REQ <= '{1'b1, wr, co, sl, a, d};
		@(posedge CLK);
		REQ <= '{1'b0, ~wr, ~co, ~sl, ~a, ~d};
	endtask
endmodule

// ===== verification/tacr_regs_tb_top.sv
// Self-checking bench for the register bank
module tacr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tacr_pkg::*;
	logic CLK, SYS_RST, NV_VALID, NV_SAVE, FRAME_FREEZE, COUNTER_RESET;
	logic SOFT_ALARM, OUTPUT_CLEAR, SWITCH_OUT, SWITCH_DRIVE_SINK;
	logic [3:0] NV_COILS, COIL_OUT;
	logic [191:0] NV_HOLD, HOLD_OUT, dflt;
	logic [15:0] f1max, f1min, f2t, f3t, lo [12], hi [12];
	logic [7:0] func_en;
	tacr_req_t REQ;
	tacr_rsp_t RSP;
	tacr_alarm_t ALARM;
	int fails = 0, n_compared = 0;
	tacr_regs i_dut (.CLK, .SYS_RST, .REQ, .RSP, .NV_VALID, .NV_HOLD,
		.NV_COILS, .NV_SAVE, .FUNC1_MIN(f1min), .FUNC1_MAX(f1max),
		.FUNC2_TEMP(f2t), .FUNC3_TEMP(f3t), .FUNC_EN(func_en),
		.HOLD_OUT, .COIL_OUT, .FRAME_FREEZE, .COUNTER_RESET, .ALARM,
		.SOFT_ALARM, .OUTPUT_CLEAR, .SWITCH_OUT, .SWITCH_DRIVE_SINK);
	tacr_master i_mst (.CLK, .REQ);
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	task automatic chk(string what, logic [191:0] exp, got);
		n_compared++;
		if (exp !== got) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic req(logic wr, co, logic [7:0] sl, logic [15:0] a, d,
		logic err);
		i_mst.xfer(wr, co, sl, a, d);
		#1;
		chk("answer", {sl != 0, err && sl != 0}, {RSP.valid, RSP.error});
		if (err)
			chk("exception", EXC_ILLEGAL_VALUE, RSP.exc_code);
	endtask
	task automatic do_reset(logic nv);
		@(posedge CLK);
		NV_VALID <= nv;
		SYS_RST <= 1'b1;
		repeat (16) @(posedge CLK);
		SYS_RST <= 1'b0;
		repeat (3) @(posedge CLK);
		#1;
	endtask
	task automatic t_alarm;
		@(posedge CLK);
		f1max <= 16'h1388;
		repeat (4) @(posedge CLK);
		#1;
		chk("hot1", 1'b1, ALARM.hot1);
		chk("soft alarm", 1'b1, SOFT_ALARM);
		chk("switch", 1'b0, SWITCH_OUT);
		@(posedge CLK);
		f1max <= 16'h0bb8;
		repeat (4) @(posedge CLK);
		#1;
		chk("hot1 gone", 1'b0, ALARM.hot1);
		req(1'b1, 1'b0, 8'h01, HR_MODE, 16'h0003, 1'b0);
		@(posedge CLK);
		func_en <= 8'h07;
		f1min <= 16'h0a00;
		f2t <= 16'h0a00;
		f3t <= 16'h1388;
		repeat (4) @(posedge CLK);
		#1;
		chk("alarms a", 6'b010110, ALARM);
		@(posedge CLK);
		f2t <= 16'h1388;
		f3t <= 16'h0a00;
		repeat (4) @(posedge CLK);
		#1;
		chk("alarms b", 6'b011001, ALARM);
		@(posedge CLK);
		f1min <= 16'h0d00;
		f2t <= 16'h0d00;
		f3t <= 16'h0d00;
		// Action mode: output held until the master clears the flag
		req(1'b1, 1'b1, 8'h01, COIL_TIMER, 16'h0000, 1'b0);
		req(1'b1, 1'b1, 8'h01, COIL_OUT_EN, 16'h0001, 1'b0);
		@(posedge CLK);
		f1max <= 16'h1388;
		repeat (4) @(posedge CLK);
		#1;
		chk("switch on", 1'b1, SWITCH_OUT);
		chk("clear set", 1'b1, OUTPUT_CLEAR);
		@(posedge CLK);
		f1max <= 16'h0bb8;
		repeat (4) @(posedge CLK);
		#1;
		chk("switch held", 1'b1, SWITCH_OUT);
		req(1'b1, 1'b1, 8'h01, COIL_CLEAR, 16'h0000, 1'b0);
		repeat (3) @(posedge CLK);
		#1;
		chk("clear gone", 1'b0, OUTPUT_CLEAR);
		chk("switch off", 1'b0, SWITCH_OUT);
		req(1'b1, 1'b1, 8'h01, COIL_OUT_EN, 16'h0000, 1'b0);
		req(1'b1, 1'b1, 8'h01, COIL_TIMER, 16'h0001, 1'b0);
		$display("end alarm");
	endtask
	task automatic t_ranges;
		logic [15:0] a;
		for (int i = 0; i < 12; i++) begin
			a = 16'(i + 2);
			req(1'b1, 1'b0, 8'h01, a, lo[i] - 16'h1, 1'b1);
			req(1'b1, 1'b0, 8'h01, a, hi[i] + 16'h1, 1'b1);
			req(1'b1, 1'b0, 8'h01, a, hi[i], 1'b0);
			req(1'b1, 1'b0, 8'h01, a, lo[i], 1'b0);
			chk("stored", lo[i], HOLD_OUT[16*i+:16]);
		end
		req(1'b1, 1'b0, 8'h01, HR_AREA, 16'h0003, 1'b1);
		req(1'b1, 1'b0, 8'h01, HR_MODE, 16'h0002, 1'b0);
		chk("mode", 16'h0002, HOLD_OUT[191:176]);
		$display("end ranges");
	endtask
	task automatic t_bcast;
		i_mst.xfer(1'b1, 1'b0, BCAST_ADDR, HR_F3_HOT, 16'h1388);
		#1;
		chk("bcast answer", 1'b0, RSP.valid);
		chk("bcast value", 16'h1388, HOLD_OUT[79:64]);
		req(1'b0, 1'b0, 8'h05, HR_F3_HOT, 16'h0000, 1'b0);
		chk("read", 16'h1388, RSP.data);
		$display("end broadcast");
	endtask
	task automatic t_coils;
		req(1'b1, 1'b1, 8'h01, COIL_SENSE, 16'h0100, 1'b0);
		req(1'b1, 1'b1, 8'h01, COIL_DRIVE, 16'h0000, 1'b0);
		req(1'b1, 1'b1, 8'h01, COIL_FREEZE, 16'h0001, 1'b0);
		req(1'b1, 1'b1, 8'h01, COIL_CNT_RST, 16'h0001, 1'b0);
		repeat (3) @(posedge CLK);
		#1;
		chk("coils", 4'h6, COIL_OUT);
		chk("switch nc", 1'b1, SWITCH_OUT);
		chk("drive held", 1'b1, SWITCH_DRIVE_SINK);
		chk("freeze", 1'b1, FRAME_FREEZE);
		chk("cnt reset", 1'b1, COUNTER_RESET);
		do_reset(1'b1);
		chk("nv hold", NV_HOLD, HOLD_OUT);
		chk("nv coils", NV_COILS, COIL_OUT);
		chk("freeze lost", 1'b0, FRAME_FREEZE);
		chk("cnt reset lost", 1'b0, COUNTER_RESET);
		chk("drive new", 1'b0, SWITCH_DRIVE_SINK);
		$display("end coils");
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		SYS_RST = 1'b1;
		NV_VALID = 1'b0;
		NV_COILS = 4'h6;
		NV_HOLD = {12{16'h0010}};
		f1max = 16'h0bb8;
		f1min = 16'h0d00;
		f2t = 16'h0d00;
		f3t = 16'h0d00;
		func_en = 8'h01;
		dflt = {MODE_RST, REGION_RST, AVG_RST, AREA_RST, EMISS_RST, ON_RST,
			COLD_RST, HOT_RST, COLD_RST, HOT_RST, COLD_RST, HOT_RST};
		lo = '{THR_MIN, THR_MIN, THR_MIN, THR_MIN, THR_MIN, THR_MIN,
			ON_MIN, EMISS_MIN, AREA_MIN, AVG_MIN, REGION_MIN, MODE_MIN};
		hi = '{THR_MAX, THR_MAX, THR_MAX, THR_MAX, THR_MAX, THR_MAX,
			ON_MAX, EMISS_MAX, AREA_MAX, AVG_MAX, REGION_MAX, MODE_MAX};
		do_reset(1'b0);
		chk("defaults", dflt, HOLD_OUT);
		chk("coil defaults", COIL_RST, COIL_OUT);
		t_alarm();
		t_ranges();
		t_bcast();
		t_coils();
		tally_and_finish();
	end
endmodule

bind tacr_regs tacr_regs_asserts i_chk (.CLK, .SYS_RST, .REQ, .RSP,
	.NV_SAVE, .HOLD_OUT, .COIL_OUT, .SWITCH_OUT);
